//--- hw/frtd_top.sv
// The plain strobed port was left to the implementer.
`include "frtd_defs.svh"

`default_nettype none

module frtd_top
  import frtd_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        hsync_i,
  input  wire logic        vsync_i,
  output logic             freerun_active_flag_o,
  output logic             default_colour_en_o,
  output logic             default_clk_sel_o
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Absolute difference of two unsigned values
  function automatic logic [12:0] abs_diff(input logic [12:0] a,
                                           input logic [12:0] b);
    abs_diff = (a >= b) ? (a - b) : (b - a);
  endfunction

  // Horizontal threshold pair by code
  function automatic frtd_thr_s h_thr(input logic [2:0] code);
    unique case (code)
      3'b000: h_thr = '{enter: 9'h0_02, leave: 9'h0_01};
      3'b001: h_thr = '{enter: 9'h1_00, leave: 9'h0_c8};
      3'b010: h_thr = '{enter: 9'h0_80, leave: 9'h0_70};
      3'b011: h_thr = '{enter: 9'h0_40, leave: 9'h0_30};
      3'b100: h_thr = '{enter: 9'h0_20, leave: 9'h0_18};
      3'b101: h_thr = '{enter: 9'h0_10, leave: 9'h0_0c};
      3'b110: h_thr = '{enter: 9'h0_08, leave: 9'h0_06};
      3'b111: h_thr = '{enter: 9'h0_04, leave: 9'h0_03};
    endcase
  endfunction

  // Vertical threshold pair by code
  function automatic frtd_thr_s v_thr(input logic [2:0] code);
    unique case (code)
      3'b000: v_thr = '{enter: 9'h0_24, leave: 9'h0_1f};
      3'b001: v_thr = '{enter: 9'h0_12, leave: 9'h0_0f};
      3'b010: v_thr = '{enter: 9'h0_0a, leave: 9'h0_07};
      3'b011: v_thr = '{enter: 9'h0_04, leave: 9'h0_03};
      3'b100: v_thr = '{enter: 9'h0_33, leave: 9'h0_2e};
      3'b101: v_thr = '{enter: 9'h0_45, leave: 9'h0_3f};
      3'b110: v_thr = '{enter: 9'h0_86, leave: 9'h0_7f};
      3'b111: v_thr = '{enter: 9'h1_07, leave: 9'h0_ff};
    endcase
  endfunction

  // Hysteresis step: enter at or above, leave at or below, else hold
  function automatic logic hyst(input logic        cur,
                                input logic [12:0] diff,
                                input frtd_thr_s   thr);
    if (!cur) begin
      hyst = (diff >= {4'h0, thr.enter});
    end else begin
      hyst = !(diff <= {4'h0, thr.leave});
    end
  endfunction

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic [10:0] ideal_line_length_r;
  logic [11:0] ideal_field_line_count_r;
  logic [1:0]  param_filter_lock_speed_r;
  logic [2:0]  horizontal_freerun_threshold_r;
  logic [2:0]  vertical_freerun_threshold_r;
  logic        force_freerun_r;
  logic [3:0]  primary_mode_select_r;
  logic [5:0]  video_standard_select_r;

  // Software writes at the printed and chosen offsets
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ideal_line_length_r            <= `FRTD_RST_IDEAL_LL;
      ideal_field_line_count_r       <= `FRTD_RST_LCOUNT;
      param_filter_lock_speed_r      <= `FRTD_RST_LOCK_SPEED;
      horizontal_freerun_threshold_r <= `FRTD_RST_HTHR;
      vertical_freerun_threshold_r   <= `FRTD_RST_VTHR;
      force_freerun_r                <= 1'b0;
      primary_mode_select_r          <= `FRTD_RST_MODE;
      video_standard_select_r        <= `FRTD_RST_STD;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `FRTD_OFS_IDEAL_LL:   ideal_line_length_r <= reg_wdata_i[10:0];
        `FRTD_OFS_LCOUNT:
          ideal_field_line_count_r <= reg_wdata_i[11:0];
        `FRTD_OFS_LOCK_SPEED:
          param_filter_lock_speed_r <= reg_wdata_i[1:0];
        `FRTD_OFS_THRESHOLD: begin
          horizontal_freerun_threshold_r <=
            reg_wdata_i[`FRTD_HTHR_LSB +: 3];
          vertical_freerun_threshold_r <=
            reg_wdata_i[`FRTD_VTHR_LSB +: 3];
        end
        `FRTD_OFS_FORCE:      force_freerun_r <= reg_wdata_i[0];
        `FRTD_OFS_MODE_STD: begin
          primary_mode_select_r   <= reg_wdata_i[3:0];
          video_standard_select_r <= reg_wdata_i[`FRTD_STD_LSB +: 6];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Ideal values: decoded table or manual override
  // ----------------------------------------------------------------------
  frtd_std_s   std_ideal;
  logic [10:0] ideal_ll;
  logic [11:0] ideal_lines;

  frtd_std_rom u_std_rom (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .addr_i    ({primary_mode_select_r[1:0],
                 video_standard_select_r[3:0]}),
    .data_o    (std_ideal)
  );

  // Manual fields feed only the decision, never the table
  assign ideal_ll = (ideal_line_length_r != 11'h000) ?
                    ideal_line_length_r : std_ideal.line_len;
  assign ideal_lines = (ideal_field_line_count_r != 12'h000) ?
                       ideal_field_line_count_r : std_ideal.lines;

  // ----------------------------------------------------------------------
  // Sync inputs: two-stage synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic [1:0] hs_sync_r;
  logic [1:0] vs_sync_r;
  logic       hs_last_r;
  logic       vs_last_r;
  logic       line_end;
  logic       field_end;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hs_sync_r <= 2'b00;
      vs_sync_r <= 2'b00;
      hs_last_r <= 1'b0;
      vs_last_r <= 1'b0;
    end else begin
      hs_sync_r <= {hs_sync_r[0], hsync_i};
      vs_sync_r <= {vs_sync_r[0], vsync_i};
      hs_last_r <= hs_sync_r[1];
      vs_last_r <= vs_sync_r[1];
    end
  end

  assign line_end  = hs_sync_r[1] & ~hs_last_r;
  assign field_end = vs_sync_r[1] & ~vs_last_r;

  // ----------------------------------------------------------------------
  // Crystal-rate enable from a phase accumulator
  // ----------------------------------------------------------------------
  logic [23:0] nco_r;
  logic [24:0] nco_sum;
  logic        xtal_en_r;

  assign nco_sum = {1'b0, nco_r} + {1'b0, 24'(`FRTD_NCO_INC)};

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nco_r     <= 24'h00_0000;
      xtal_en_r <= 1'b0;
    end else begin
      nco_r     <= nco_sum[23:0];
      xtal_en_r <= nco_sum[24];
    end
  end

  // ----------------------------------------------------------------------
  // Line length in crystal cycles, lines per field
  // ----------------------------------------------------------------------
  logic [11:0] ll_cnt_r;
  logic [12:0] ln_cnt_r;
  logic [11:0] meas_ll_r;
  logic [12:0] meas_lines_r;
  logic        ll_valid_r;
  logic        ln_valid_r;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ll_cnt_r   <= 12'h000;
      meas_ll_r  <= 12'h000;
      ll_valid_r <= 1'b0;
    end else begin
      ll_valid_r <= line_end;
      if (line_end) begin
        meas_ll_r <= ll_cnt_r;
        ll_cnt_r  <= 12'h000;
      end else if (xtal_en_r && ll_cnt_r != `FRTD_LL_CNT_MAX) begin
        ll_cnt_r <= ll_cnt_r + 12'h001;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ln_cnt_r     <= 13'h0000;
      meas_lines_r <= 13'h0000;
      ln_valid_r   <= 1'b0;
    end else begin
      ln_valid_r <= field_end;
      if (field_end) begin
        meas_lines_r <= ln_cnt_r;
        ln_cnt_r     <= 13'h0000;
      end else if (line_end && ln_cnt_r != `FRTD_LN_CNT_MAX) begin
        ln_cnt_r <= ln_cnt_r + 13'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Free-run decision with hysteresis per axis
  // ----------------------------------------------------------------------
  logic [12:0] h_diff;
  logic [12:0] v_diff;
  logic        h_fail_r;
  logic        v_fail_r;
  logic        h_lost;
  logic        v_lost;

  assign h_diff = abs_diff({1'b0, meas_ll_r}, {2'b00, ideal_ll});
  assign v_diff = abs_diff(meas_lines_r, {1'b0, ideal_lines});
  // A saturated counter means the sync has gone missing
  assign h_lost = (ll_cnt_r == `FRTD_LL_CNT_MAX);
  assign v_lost = (ln_cnt_r == `FRTD_LN_CNT_MAX) || h_lost;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      h_fail_r <= 1'b0;
    end else if (h_lost) begin
      h_fail_r <= 1'b1;
    end else if (ll_valid_r && ideal_ll != 11'h000) begin
      h_fail_r <= hyst(h_fail_r, h_diff,
                       h_thr(horizontal_freerun_threshold_r));
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      v_fail_r <= 1'b0;
    end else if (v_lost) begin
      v_fail_r <= 1'b1;
    end else if (ln_valid_r && ideal_lines != 12'h000) begin
      v_fail_r <= hyst(v_fail_r, v_diff,
                       v_thr(vertical_freerun_threshold_r));
    end
  end

  // Overall state and the outputs that follow it
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      freerun_active_flag_o <= 1'b0;
      default_colour_en_o   <= 1'b0;
      default_clk_sel_o     <= 1'b0;
    end else begin
      freerun_active_flag_o <= force_freerun_r | h_fail_r | v_fail_r;
      default_colour_en_o   <= force_freerun_r | h_fail_r | v_fail_r;
      default_clk_sel_o     <= force_freerun_r | h_fail_r | v_fail_r;
    end
  end

  // ----------------------------------------------------------------------
  // Buffered line length filter, one fractional bit
  // ----------------------------------------------------------------------
  logic [11:0] filt_ll_r;
  logic [12:0] filt_err;
  logic [12:0] filt_step;
  logic [11:0] filt_target;

  assign filt_target = meas_ll_r[11] ? 12'hfff : {meas_ll_r[10:0], 1'b0};
  assign filt_err    = {1'b0, filt_target} - {1'b0, filt_ll_r};

  // Step size by locking speed; never stalls short of the target
  always_comb begin
    unique case (frtd_lock_e'(param_filter_lock_speed_r))
      FRTD_LOCK_SLOW:  filt_step = $signed(filt_err) >>> 4;
      FRTD_LOCK_MED:   filt_step = $signed(filt_err) >>> 2;
      FRTD_LOCK_FAST:  filt_step = $signed(filt_err) >>> 1;
      FRTD_LOCK_FIXED: filt_step = filt_err[12] ? 13'h1fff : 13'h0001;
    endcase
    if (filt_err == 13'h0000) begin
      filt_step = 13'h0000;
    end else if (filt_step == 13'h0000 || filt_step == 13'h1fff) begin
      filt_step = filt_err[12] ? 13'h1fff : 13'h0001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      filt_ll_r <= 12'h000;
    end else if (ll_valid_r) begin
      filt_ll_r <= filt_ll_r + filt_step[11:0];
    end
  end

  // ----------------------------------------------------------------------
  // Read port: data stand only in the cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      unique case (reg_addr_i)
        `FRTD_OFS_IDEAL_LL:   reg_rdata_o <= {5'h00, ideal_line_length_r};
        `FRTD_OFS_LCOUNT:
          reg_rdata_o <= {4'h0, ideal_field_line_count_r};
        `FRTD_OFS_LOCK_SPEED:
          reg_rdata_o <= {14'h0000, param_filter_lock_speed_r};
        `FRTD_OFS_THRESHOLD:
          reg_rdata_o <= {10'h000, vertical_freerun_threshold_r,
                          horizontal_freerun_threshold_r};
        `FRTD_OFS_FORCE:      reg_rdata_o <= {15'h0000, force_freerun_r};
        `FRTD_OFS_MODE_STD:
          reg_rdata_o <= {6'h00, video_standard_select_r,
                          primary_mode_select_r};
        `FRTD_OFS_STATUS:
          reg_rdata_o <= {13'h0000, v_fail_r, h_fail_r,
                          freerun_active_flag_o};
        `FRTD_OFS_MEAS_LL:    reg_rdata_o <= {4'h0, meas_ll_r};
        `FRTD_OFS_MEAS_LINES: reg_rdata_o <= {3'h0, meas_lines_r};
        `FRTD_OFS_FILT_LL:    reg_rdata_o <= {4'h0, filt_ll_r};
        default:              reg_rdata_o <= 16'h0000;
      endcase
    end
  end

endmodule

`default_nettype wire

//--- hw/frtd_defs.svh
`ifndef FRTD_DEFS_SVH
`define FRTD_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FRTD_OFS_MODE_STD     8'h05
`define FRTD_OFS_STATUS       8'h10
`define FRTD_OFS_MEAS_LL      8'h11
`define FRTD_OFS_MEAS_LINES   8'h12
`define FRTD_OFS_FILT_LL      8'h13
`define FRTD_OFS_IDEAL_LL     8'h8f
`define FRTD_OFS_LCOUNT       8'hab
`define FRTD_OFS_FORCE        8'hbf
`define FRTD_OFS_LOCK_SPEED   8'hcb
`define FRTD_OFS_THRESHOLD    8'hf3

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FRTD_HTHR_LSB         0
`define FRTD_VTHR_LSB         3
`define FRTD_STD_LSB          4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FRTD_RST_IDEAL_LL     11'h000
`define FRTD_RST_LCOUNT       12'h000
`define FRTD_RST_LOCK_SPEED   2'h0
`define FRTD_RST_HTHR         3'h4
`define FRTD_RST_VTHR         3'h2
`define FRTD_RST_MODE         4'h0
`define FRTD_RST_STD          6'h00

// ----------------------------------------------------------------------
// Timing: crystal rate derived from the system clock by an NCO
// ----------------------------------------------------------------------
`define FRTD_SYS_HZ           64'd100000000
`define FRTD_XTAL_HZ          64'd28636300
`define FRTD_NCO_ONE          64'd16777216
`define FRTD_NCO_INC \
  ((`FRTD_XTAL_HZ * `FRTD_NCO_ONE) / `FRTD_SYS_HZ)

// Saturation points that stand for a missing sync
`define FRTD_LL_CNT_MAX       12'hfff
`define FRTD_LN_CNT_MAX       13'h1fff

`endif

//--- hw/frtd_pkg.sv
`default_nettype none

package frtd_pkg;

  // Enter / exit pair of a hysteresis threshold
  typedef struct packed {
    logic [8:0] enter;
    logic [8:0] leave;
  } frtd_thr_s;

  // Ideal timing of one mode and standard
  typedef struct packed {
    logic [11:0] lines;
    logic [10:0] line_len;
  } frtd_std_s;

  // Locking speed of the parameter filter
  typedef enum logic [1:0] {
    FRTD_LOCK_SLOW  = 2'b00,
    FRTD_LOCK_MED   = 2'b01,
    FRTD_LOCK_FAST  = 2'b10,
    FRTD_LOCK_FIXED = 2'b11
  } frtd_lock_e;

endpackage

`default_nettype wire

//--- hw/frtd_std_rom.sv
`default_nettype none

module frtd_std_rom
  import frtd_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [5:0] addr_i,
  output var  frtd_std_s  data_o
);

  // ----------------------------------------------------------------------
  // Ideal timings, {mode[1:0], std[3:0]}; zero means not covered
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_o <= '0;
    end else begin
      unique case (addr_i)
        6'h00:   data_o <= '{lines: 12'h2_0d, line_len: 11'h3_8c};
        6'h01:   data_o <= '{lines: 12'h2_71, line_len: 11'h3_94};
        6'h02:   data_o <= '{lines: 12'h2_ee, line_len: 11'h2_7c};
        6'h10:   data_o <= '{lines: 12'h2_0d, line_len: 11'h3_8d};
        6'h11:   data_o <= '{lines: 12'h2_74, line_len: 11'h2_f2};
        6'h12:   data_o <= '{lines: 12'h3_26, line_len: 11'h2_4e};
        6'h13:   data_o <= '{lines: 12'h4_2a, line_len: 11'h1_be};
        default: data_o <= '0;
      endcase
    end
  end

endmodule

`default_nettype wire

//--- bench/frtd_top_assertions.sv
`default_nettype none

module frtd_top_assertions (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_rdata_o,
  input  wire logic        hsync_i,
  input  wire logic        vsync_i,
  input  wire logic        freerun_active_flag_o,
  input  wire logic        default_colour_en_o,
  input  wire logic        default_clk_sel_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0]  lock_r;
  logic [10:0] ll_r;
  logic [5:0]  thr_r;
  logic        frc_r;

  // ------------------------------------------------------------
  // Shadow copies of writable settings
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lock_r <= 2'h0;
      ll_r   <= 11'h000;
      thr_r  <= 6'h14;
      frc_r  <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 8'hcb) lock_r <= reg_wdata_i[1:0];
      if (reg_addr_i == 8'h8f) ll_r <= reg_wdata_i[10:0];
      if (reg_addr_i == 8'hf3) thr_r <= reg_wdata_i[5:0];
      if (reg_addr_i == 8'hbf) frc_r <= reg_wdata_i[0];
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence rd_of(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence

  colour_follow_a: assert property (
    default_colour_en_o == freerun_active_flag_o)
    else $error("default colour differs from free-run flag");
  clock_follow_a: assert property (
    default_clk_sel_o == freerun_active_flag_o)
    else $error("default clock select differs from free-run flag");
  reset_quiet_a: assert property (
    $rose(reset_n_i) |-> !freerun_active_flag_o)
    else $error("flag high right after reset");
  rdata_idle_a: assert property (
    !reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside a read");
  force_on_a: assert property (
    frc_r |=> freerun_active_flag_o)
    else $error("forced free run not shown on flag");
  lock_read_a: assert property (
    rd_of(8'hcb) |=> reg_rdata_o == {14'h0000, $past(lock_r)})
    else $error("lock speed readback wrong");
  line_read_a: assert property (
    rd_of(8'h8f) |=> reg_rdata_o == {5'h00, $past(ll_r)})
    else $error("ideal line length readback wrong");
  thr_read_a: assert property (
    rd_of(8'hf3) |=> reg_rdata_o == {10'h000, $past(thr_r)})
    else $error("threshold readback wrong");
endmodule

`default_nettype wire

//--- bench/frtd_sync_src.sv
`default_nettype none

module frtd_sync_src (
  input  wire logic        clk_i,
  input  wire logic        en_i,
  input  wire logic [15:0] period_i,
  input  wire logic [11:0] lines_i,
  output logic             hsync_o,
  output logic             vsync_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] pix_r;
  logic [11:0] line_r;
  logic        eol;

  assign eol = pix_r >= period_i - 16'h0001;

  // Position within the line
  always_ff @(posedge clk_i) begin
    if (!en_i || eol) pix_r <= 16'h0000;
    else pix_r <= pix_r + 16'h0001;
  end

  // Line within the field
  always_ff @(posedge clk_i) begin
    if (!en_i) line_r <= 12'h000;
    else if (eol) line_r <= (line_r >= lines_i - 12'h001) ? 12'h000
                                                          : line_r + 12'h001;
  end

  // Four-clock pulses; field pulse sits mid-line, silent when stopped
  assign hsync_o = en_i && pix_r < 16'h0004;
  assign vsync_o = en_i && line_r == 12'h000 &&
                   pix_r >= {1'b0, period_i[15:1]} &&
                   pix_r < {1'b0, period_i[15:1]} + 16'h0004;
endmodule

`default_nettype wire

//--- bench/frtd_bench.sv
`default_nettype none

module frtd_bench;
  import frtd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        hs;
  logic        vs;
  logic        flag;
  logic        colour;
  logic        dclk;
  logic        src_en;
  logic [15:0] src_per;
  logic [11:0] src_lines;
  logic [15:0] rv;
  logic        in_rng;
  int          err_count;
  int          check_count;
  logic [8:0]  hen [8] = '{9'h002, 9'h100, 9'h080, 9'h040,
                           9'h020, 9'h010, 9'h008, 9'h004};
  logic [8:0]  hlv [8] = '{9'h001, 9'h0c8, 9'h070, 9'h030,
                           9'h018, 9'h00c, 9'h006, 9'h003};
  logic [8:0]  ven [8] = '{9'h024, 9'h012, 9'h00a, 9'h004,
                           9'h033, 9'h045, 9'h086, 9'h107};
  logic [8:0]  vlv [8] = '{9'h01f, 9'h00f, 9'h007, 9'h003,
                           9'h02e, 9'h03f, 9'h07f, 9'h0ff};

  frtd_top DUT (.sys_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .hsync_i(hs), .vsync_i(vs), .freerun_active_flag_o(flag),
    .default_colour_en_o(colour), .default_clk_sel_o(dclk));
  frtd_sync_src SRC (.clk_i(clk), .en_i(src_en), .period_i(src_per),
    .lines_i(src_lines), .hsync_o(hs), .vsync_o(vs));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wait_flag(input logic e, input int bound);
    int n;
    n = 0;
    while (flag !== e && n < bound) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("freerun flag", {15'h0000, flag}, {15'h0000, e});
    if (flag !== e) wrap_up();
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check("flag at reset", {15'h0000, flag}, 16'h0000);
    rd_reg(8'hf3, rv);
    check("thresholds", rv, 16'h0014);
    rd_reg(8'h8f, rv);
    check("ideal line length", rv, 16'h0000);
    rd_reg(8'hcb, rv);
    check("lock speed", rv, 16'h0000);
    rd_reg(8'hab, rv);
    check("field line count", rv, 16'h0000);
    rd_reg(8'h00, rv);
    check("unmapped", rv, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_lock();
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'hcb, {14'h0000, i[1:0]});
      rd_reg(8'hcb, rv);
      check("lock speed", rv, {14'h0000, i[1:0]});
    end
    $display("lock speed test done");
  endtask
  task automatic t_force();
    wr_reg(8'hbf, 16'h0001);
    @(posedge clk);
    #1;
    check("forced flag", {15'h0000, flag}, 16'h0001);
    check("colour", {15'h0000, colour}, 16'h0001);
    check("own clock", {15'h0000, dclk}, 16'h0001);
    rd_reg(8'h10, rv);
    check("status", rv & 16'h0001, 16'h0001);
    wr_reg(8'hbf, 16'h0000);
    wait_flag(1'b0, 100);
    $display("force test done");
  endtask
  task automatic t_hyst();
    wr_reg(8'h8f, 16'h0045);
    wait_flag(1'b1, 400);
    wr_reg(8'h8f, 16'h0039);
    repeat (500) @(posedge clk);
    check("held high", {15'h0000, flag}, 16'h0001);
    wr_reg(8'h8f, 16'h0034);
    wait_flag(1'b0, 400);
    wr_reg(8'h8f, 16'h0039);
    repeat (500) @(posedge clk);
    check("held low", {15'h0000, flag}, 16'h0000);
    wr_reg(8'h8f, 16'h001d);
    wr_reg(8'hab, 16'h0001);
    wait_flag(1'b1, 3000);
    wr_reg(8'hab, 16'h0005);
    wait_flag(1'b0, 3000);
    wr_reg(8'hab, 16'h000c);
    $display("hysteresis test done");
  endtask
  task automatic t_hcodes();
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h8f, 16'h001d);
      wr_reg(8'hf3, {10'h000, 3'h2, i[2:0]});
      wr_reg(8'h8f, 16'h001d + {7'h00, hen[i]});
      wait_flag(1'b1, 400);
      wr_reg(8'h8f, 16'h001c + {7'h00, hlv[i]});
      wait_flag(1'b0, 400);
    end
    wr_reg(8'h8f, 16'h001d);
    $display("horizontal code test done");
  endtask
  task automatic t_vcodes();
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'hab, 16'h000c);
      wr_reg(8'hf3, {10'h000, i[2:0], 3'h4});
      wr_reg(8'hab, 16'h000c + {7'h00, ven[i]});
      wait_flag(1'b1, 3000);
      wr_reg(8'hab, 16'h000c + {7'h00, vlv[i]});
      wait_flag(1'b0, 3000);
    end
    wr_reg(8'hab, 16'h000c);
    wr_reg(8'hf3, 16'h0014);
    // Steady 100-clock lines: about 28.6 crystal cycles, 12 lines
    rd_reg(8'h11, rv);
    in_rng = (rv >= 16'h001b) && (rv <= 16'h001d);
    check("line length", {15'h0000, in_rng}, 16'h0001);
    rd_reg(8'h12, rv);
    check("field lines", rv, 16'h000c);
    // Fixed half-cycle steps keep the filter on twice the length
    rd_reg(8'h13, rv);
    in_rng = (rv >= 16'h0036) && (rv <= 16'h003a);
    check("filtered length", {15'h0000, in_rng}, 16'h0001);
    $display("vertical code test done");
  endtask
  task automatic t_decode();
    wr_reg(8'hab, 16'h0000);
    wait_flag(1'b1, 3000);
    wr_reg(8'hab, 16'h000c);
    wait_flag(1'b0, 3000);
    wr_reg(8'h8f, 16'h0000);
    wait_flag(1'b1, 400);
    src_per <= 16'h0c63;
    wait_flag(1'b0, 10000);
    wr_reg(8'h05, 16'h0031);
    wait_flag(1'b1, 10000);
    wr_reg(8'h05, 16'h0000);
    wait_flag(1'b0, 10000);
    $display("decoded value test done");
  endtask
  task automatic t_loss();
    src_en <= 1'b0;
    wait_flag(1'b1, 20000);
    $display("signal loss test done");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    src_en = 1'b0;
    src_per = 16'h0064;
    src_lines = 12'h00c;
    err_count = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    src_en <= 1'b1;
    wr_reg(8'h8f, 16'h001d);
    wr_reg(8'hab, 16'h000c);
    // First field is partial and may trip the vertical check
    repeat (2600) @(posedge clk);
    wait_flag(1'b0, 3000);
    t_lock();
    t_force();
    t_hyst();
    t_hcodes();
    t_vcodes();
    t_decode();
    t_loss();
    wrap_up();
  end
endmodule

bind frtd_top frtd_top_assertions CHK (.sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .hsync_i(hsync_i), .vsync_i(vsync_i),
  .freerun_active_flag_o(freerun_active_flag_o),
  .default_colour_en_o(default_colour_en_o),
  .default_clk_sel_o(default_clk_sel_o));

`default_nettype wire
